/* File: hw/cxe_top.sv */
// Exception, interrupt and reset entry unit of the processor.
//
// Overview of operation
// - Timers form one request source; timer 0 beats timer 1; own vectors each.
// - Default source order applies unless software gives every source unique levels.
// - Coprocessor opcodes D8H-DFH trap to type 7 only with relocation trap bit.
// - Coprocessor trap returns to the opcode or its preceding segment prefix.
// - Breakpoint instruction enters type 3, pointer at table byte address 12.
// - Overflow check enters type 4 only when the overflow flag is set.
// - Range check enters type 5 when index lies outside memory bounds.
// - Undefined opcodes enter type 6.
// - Pin, DMA and timer requests are taken only while interrupt enable set.
// - Entry saves status word first, then clears interrupt enable until software sets.
// - Handler return restores status; pending request is entered before any instruction.
// - Non-maskable request ignores enable, vector 2, no acknowledge cycle, clears enable.
// - Single-step flag causes vector 1 entry after next instruction, clearing the flag.
// - While power-on clear is low nothing executes and no bus cycle starts.
// - After release and a startup interval fetching starts at FFFF0H.
// - Reset loads status F002H, code segment FFFFH, pointer and segments 0000H.
// - Processor clock is the time base divided by two.
// - Entry pushes status, code segment and pointer before transferring control.
// - Handlers found at vector times four; hardware sampled at instruction boundaries.
// - Other exceptions return to the instruction after the faulting one.
// - No single-step entry after prefixes, segment loads or the wait instruction.
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`include "cxe_map.svh"
module cxe_top #(
  parameter int STARTUP_CYC = `CXE_STARTUP_CYC
) (
  input wire logic CLK_SYS_I, // System clock, 25 MHz.
  input wire logic RST_B_I, // Synchronous reset, active low.
  input wire logic POWER_ON_CLEAR_IN_N_I, // Processor reset pin, active low.
  input wire logic [3:0] MASKABLE_REQUEST_PINS_I, // Maskable request pins.
  input wire logic NMI_PIN_I, // Non-maskable request pin, rising edge.
  input wire logic [1:0] DMA_REQ_I, // DMA channel requests.
  input wire logic [2:0] TIMER_REQ_I, // Timer requests.
  input wire logic BOUNDARY_I, // Instruction completes this cycle.
  input wire logic [7:0] OPCODE_I, // Opcode of that instruction.
  input wire logic UNDEF_OP_I, // Opcode is undefined.
  input wire logic BREAKPOINT_I, // Instruction is the breakpoint.
  input wire logic OVF_CHECK_I, // Instruction is the overflow check.
  input wire logic OVERFLOW_FLAG_I, // Current overflow flag.
  input wire logic RANGE_CHECK_I, // Instruction is the range check.
  input wire logic [15:0] RANGE_INDEX_I, // Index operand.
  input wire logic [15:0] RANGE_LOW_I, // Lower bound read from memory.
  input wire logic [15:0] RANGE_HIGH_I, // Upper bound read from memory.
  input wire logic SEG_PREFIX_I, // Segment prefix precedes the opcode.
  input wire logic NO_STEP_I, // Prefix, segment load or wait.
  input wire logic RETURN_FROM_HANDLER_I, // Instruction is the handler return.
  input wire logic [15:0] POPPED_STATUS_I, // Status word popped by it.
  input wire logic STATUS_WR_I, // Software writes the status word.
  input wire logic [15:0] STATUS_DATA_I, // Value written.
  input wire logic [15:0] INSTR_CS_I, // Code segment of the instruction.
  input wire logic [15:0] INSTR_IP_I, // Pointer of the opcode byte.
  input wire logic [15:0] NEXT_IP_I, // Pointer of the next instruction.
  output logic CORE_HOLD_O, // Core must not start an instruction.
  output logic CLK_DIV2_O, // Processor clock, time base halved.
  output logic FETCH_GO_O, // Start fetching at FETCH_ADDR_O.
  output logic [19:0] FETCH_ADDR_O, // Startup fetch address.
  output logic SEG_LOAD_O, // Load segment registers from below.
  output logic [15:0] SEG_CS_O, // Code segment load value.
  output logic [15:0] SEG_OTHER_O, // Data, extra, stack and pointer value.
  output logic STACK_WR_O, // Push STACK_DATA_O.
  output logic [15:0] STACK_DATA_O, // Word pushed on entry.
  output logic VEC_FETCH_O, // Fetch handler pointer.
  output logic [9:0] VEC_TABLE_ADDR_O, // Pointer table byte address.
  output logic [7:0] VEC_TYPE_O, // Vector type of the entry.
  output logic ACK_CYCLE_O, // Entry needs an acknowledge cycle.
  output logic [15:0] STATUS_WORD_O, // Current status word.
  input wire logic [7:0] S_AXI_AWADDR_I, // Write address.
  input wire logic S_AXI_AWVALID_I, // Write address valid.
  output logic S_AXI_AWREADY_O, // Write address ready.
  input wire logic [31:0] S_AXI_WDATA_I, // Write data.
  input wire logic [3:0] S_AXI_WSTRB_I, // Write byte strobes.
  input wire logic S_AXI_WVALID_I, // Write data valid.
  output logic S_AXI_WREADY_O, // Write data ready.
  output logic [1:0] S_AXI_BRESP_O, // Write response.
  output logic S_AXI_BVALID_O, // Write response valid.
  input wire logic S_AXI_BREADY_I, // Write response ready.
  input wire logic [7:0] S_AXI_ARADDR_I, // Read address.
  input wire logic S_AXI_ARVALID_I, // Read address valid.
  output logic S_AXI_ARREADY_O, // Read address ready.
  output logic [31:0] S_AXI_RDATA_O, // Read data.
  output logic [1:0] S_AXI_RRESP_O, // Read response.
  output logic S_AXI_RVALID_O, // Read data valid.
  input wire logic S_AXI_RREADY_I // Read data ready.
);
  function automatic logic [31:0] merge32(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic known(input logic [7:0] a);
    return a == `CXE_OFF_RELOC || a == `CXE_OFF_USEL || a == `CXE_OFF_PRIO ||
           a == `CXE_OFF_STATE || a == `CXE_OFF_LASTVEC;
  endfunction

  cxe_pkg::cxe_state_s q;
  cxe_pkg::cxe_state_s n;
  cxe_req_if rq ();
  logic cop_op;
  logic cop_trap;
  logic ovf_trap;
  logic range_bad;
  logic exc_any;
  logic [7:0] exc_vec;
  logic [15:0] sw_eff;
  logic mask_take;
  logic step_take;
  logic take;
  logic [7:0] ent_vec;
  logic [15:0] ent_ip;
  logic nmi_edge;
  logic [31:0] rd_word;

  cxe_prio u_prio (
    .rq(rq)
  );

  assign rq.req = {q.pin_s2, DMA_REQ_I[1], DMA_REQ_I[0], |TIMER_REQ_I};
  assign rq.tmr = TIMER_REQ_I;
  assign rq.prio_cfg = q.prio;

  assign cop_op = OPCODE_I[7:3] == `CXE_COP_TOP;
  assign cop_trap = cop_op && q.reloc[`CXE_RELOC_TRAP_BIT];
  assign ovf_trap = OVF_CHECK_I && OVERFLOW_FLAG_I;
  assign range_bad = RANGE_CHECK_I &&
    ($signed(RANGE_INDEX_I) < $signed(RANGE_LOW_I) ||
     $signed(RANGE_INDEX_I) > $signed(RANGE_HIGH_I));
  assign exc_any = UNDEF_OP_I | cop_trap | BREAKPOINT_I | ovf_trap | range_bad;
  assign exc_vec = UNDEF_OP_I ? `CXE_VEC_UNDEF :
                   cop_trap ? `CXE_VEC_COP :
                   BREAKPOINT_I ? `CXE_VEC_BRK :
                   ovf_trap ? `CXE_VEC_OVF : `CXE_VEC_RANGE;
  // A restored status word takes effect at this very boundary.
  assign sw_eff = STATUS_WR_I ? STATUS_DATA_I :
                  RETURN_FROM_HANDLER_I ? POPPED_STATUS_I : q.sw;
  assign mask_take = sw_eff[`CXE_SW_IF] && rq.grant;
  assign step_take = q.sw[`CXE_SW_STEP] && !NO_STEP_I;
  assign take = exc_any | q.nmi_pend | mask_take | step_take;
  assign ent_vec = exc_any ? exc_vec :
                   q.nmi_pend ? `CXE_VEC_NMI :
                   mask_take ? rq.gvec : `CXE_VEC_STEP;
  assign ent_ip = (exc_any && !UNDEF_OP_I && cop_trap) ?
                  (SEG_PREFIX_I ? INSTR_IP_I - 16'h0001 : INSTR_IP_I) :
                  NEXT_IP_I;
  assign nmi_edge = q.nmi_s2 && !q.nmi_s3;

  always_comb begin
    rd_word = 32'h00000000;
    if (S_AXI_ARADDR_I == `CXE_OFF_RELOC) begin
      rd_word = {16'h0000, q.reloc};
    end else if (S_AXI_ARADDR_I == `CXE_OFF_USEL) begin
      rd_word = {16'h0000, q.usel};
    end else if (S_AXI_ARADDR_I == `CXE_OFF_PRIO) begin
      rd_word = {11'h000, q.prio};
    end else if (S_AXI_ARADDR_I == `CXE_OFF_STATE) begin
      rd_word = {12'h000, q.nmi_pend, q.state, q.sw};
    end else if (S_AXI_ARADDR_I == `CXE_OFF_LASTVEC) begin
      rd_word = {23'h000000, q.ack_cyc, q.vec};
    end
  end

  always_comb begin
    n = q;
    n.stk_wr = 1'b0;
    n.vec_go = 1'b0;
    n.fetch_go = 1'b0;
    n.seg_load = 1'b0;
    n.div = ~q.div;
    n.poc_s1 = POWER_ON_CLEAR_IN_N_I;
    n.poc_s2 = q.poc_s1;
    n.pin_s1 = MASKABLE_REQUEST_PINS_I;
    n.pin_s2 = q.pin_s1;
    n.nmi_s1 = NMI_PIN_I;
    n.nmi_s2 = q.nmi_s1;
    n.nmi_s3 = q.nmi_s2;
    if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      n.aw_got = 1'b1;
      n.awaddr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      n.w_got = 1'b1;
      n.wdata = S_AXI_WDATA_I;
      n.wstrb = S_AXI_WSTRB_I;
    end
    if (q.aw_got && q.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = known(q.awaddr) ? `CXE_RESP_OKAY : `CXE_RESP_DECERR;
      if (q.awaddr == `CXE_OFF_RELOC) begin
        n.reloc = 16'(merge32({16'h0000, q.reloc}, q.wdata, q.wstrb));
      end else if (q.awaddr == `CXE_OFF_USEL) begin
        n.usel = 16'(merge32({16'h0000, q.usel}, q.wdata, q.wstrb));
      end else if (q.awaddr == `CXE_OFF_PRIO) begin
        n.prio = 21'(merge32({11'h000, q.prio}, q.wdata, q.wstrb));
      end
    end else if (q.bvalid && S_AXI_BREADY_I) begin
      n.bvalid = 1'b0;
    end
    if (S_AXI_ARVALID_I && !q.rvalid) begin
      n.rvalid = 1'b1;
      n.rdata = rd_word;
      n.rresp = known(S_AXI_ARADDR_I) ? `CXE_RESP_OKAY : `CXE_RESP_DECERR;
    end else if (q.rvalid && S_AXI_RREADY_I) begin
      n.rvalid = 1'b0;
    end
    case (q.state)
      cxe_pkg::ST_HOLD: begin
        if (q.poc_s2) begin
          n.state = cxe_pkg::ST_START;
          n.cnt = 4'h0;
        end
      end
      cxe_pkg::ST_START: begin
        if (q.cnt == 4'(STARTUP_CYC - 1)) begin
          n.state = cxe_pkg::ST_RUN;
          n.fetch_go = 1'b1;
          n.seg_load = 1'b1;
        end else begin
          n.cnt = q.cnt + 4'h1;
        end
      end
      cxe_pkg::ST_RUN: begin
        n.sw = sw_eff;
        if (BOUNDARY_I && take) begin
          n.state = cxe_pkg::ST_PUSH_SW;
          n.stk_wr = 1'b1;
          n.stk_data = sw_eff;
          n.sw[`CXE_SW_IF] = 1'b0;
          n.sw[`CXE_SW_STEP] = 1'b0;
          n.vec = ent_vec;
          n.ack_cyc = !exc_any && !q.nmi_pend && rq.gpin;
          n.ret_cs = INSTR_CS_I;
          n.ret_ip = ent_ip;
          if (!exc_any) begin
            n.nmi_pend = 1'b0;
          end
        end
      end
      cxe_pkg::ST_PUSH_SW: begin
        n.state = cxe_pkg::ST_PUSH_CS;
        n.stk_wr = 1'b1;
        n.stk_data = q.ret_cs;
      end
      cxe_pkg::ST_PUSH_CS: begin
        n.state = cxe_pkg::ST_PUSH_IP;
        n.stk_wr = 1'b1;
        n.stk_data = q.ret_ip;
      end
      cxe_pkg::ST_PUSH_IP: begin
        n.state = cxe_pkg::ST_VEC;
        n.vec_go = 1'b1;
      end
      default: begin
        n.state = cxe_pkg::ST_RUN;
      end
    endcase
    // A new edge in the cycle the pending request is taken is kept.
    if (nmi_edge) begin
      n.nmi_pend = 1'b1;
    end
    if (!q.poc_s2) begin
      n.state = cxe_pkg::ST_HOLD;
      n.stk_wr = 1'b0;
      n.vec_go = 1'b0;
      // A startup pulse must not escape while the pin holds the core.
      n.fetch_go = 1'b0;
      n.seg_load = 1'b0;
      n.nmi_pend = 1'b0;
      n.sw = `CXE_RST_SW;
      n.reloc = `CXE_RST_RELOC;
      n.usel = `CXE_RST_USEL;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      q <= '0;
      q.state <= cxe_pkg::ST_HOLD;
      q.sw <= `CXE_RST_SW;
      q.reloc <= `CXE_RST_RELOC;
      q.usel <= `CXE_RST_USEL;
      q.prio <= `CXE_RST_PRIO;
    end else begin
      q <= n;
    end
  end

  assign CORE_HOLD_O = q.state != cxe_pkg::ST_RUN;
  assign CLK_DIV2_O = q.div;
  assign FETCH_GO_O = q.fetch_go;
  assign FETCH_ADDR_O = {`CXE_RST_CS, 4'h0} + {4'h0, `CXE_RST_IP};
  assign SEG_LOAD_O = q.seg_load;
  assign SEG_CS_O = `CXE_RST_CS;
  assign SEG_OTHER_O = `CXE_RST_SEG;
  assign STACK_WR_O = q.stk_wr;
  assign STACK_DATA_O = q.stk_data;
  assign VEC_FETCH_O = q.vec_go;
  assign VEC_TABLE_ADDR_O = {q.vec, 2'b00};
  assign VEC_TYPE_O = q.vec;
  assign ACK_CYCLE_O = q.ack_cyc;
  assign STATUS_WORD_O = q.sw;
  assign S_AXI_AWREADY_O = !q.aw_got && !q.bvalid;
  assign S_AXI_WREADY_O = !q.w_got && !q.bvalid;
  assign S_AXI_BVALID_O = q.bvalid;
  assign S_AXI_BRESP_O = q.bresp;
  assign S_AXI_ARREADY_O = !q.rvalid;
  assign S_AXI_RVALID_O = q.rvalid;
  assign S_AXI_RDATA_O = q.rdata;
  assign S_AXI_RRESP_O = q.rresp;

  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_B_I);

  logic run_bnd;
  assign run_bnd = BOUNDARY_I && q.state == cxe_pkg::ST_RUN && q.poc_s2;

  sequence s_push_tail;
    STACK_WR_O && STACK_DATA_O == $past(INSTR_CS_I, 2) ##1
    STACK_WR_O ##1 VEC_FETCH_O;
  endsequence

  property p_push_order;
    run_bnd && take |=> STACK_WR_O && STACK_DATA_O == $past(sw_eff) ##1
    s_push_tail;
  endproperty
  a_push_order: assert property (p_push_order) else $error("bad push order");

  property p_if_clear;
    run_bnd && take |=> !STATUS_WORD_O[`CXE_SW_IF] [*4];
  endproperty
  a_if_clear: assert property (p_if_clear) else $error("enable not cleared");

  property p_nmi;
    run_bnd && !exc_any && q.nmi_pend |=> ##3
    VEC_FETCH_O && VEC_TYPE_O == `CXE_VEC_NMI && !ACK_CYCLE_O;
  endproperty
  a_nmi: assert property (p_nmi) else $error("bad nmi entry");

  property p_mask_gate;
    run_bnd && !exc_any && !q.nmi_pend && !sw_eff[`CXE_SW_IF] &&
    !step_take |=> !STACK_WR_O;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("masked taken");

  property p_cop_ret;
    run_bnd && cop_trap && !UNDEF_OP_I |=> ##2
    STACK_DATA_O == $past(SEG_PREFIX_I ? INSTR_IP_I - 16'h0001 : INSTR_IP_I, 3);
  endproperty
  a_cop_ret: assert property (p_cop_ret) else $error("bad trap return");

  property p_step;
    run_bnd && q.sw[`CXE_SW_STEP] && !NO_STEP_I && !exc_any && !q.nmi_pend &&
    !mask_take |=> ##3 VEC_FETCH_O && VEC_TYPE_O == `CXE_VEC_STEP &&
    !STATUS_WORD_O[`CXE_SW_STEP];
  endproperty
  a_step: assert property (p_step) else $error("bad step entry");

  property p_hold;
    !q.poc_s2 |=> CORE_HOLD_O && !STACK_WR_O && !VEC_FETCH_O;
  endproperty
  a_hold: assert property (p_hold) else $error("activity in reset");

  property p_start;
    FETCH_GO_O |-> FETCH_ADDR_O == 20'hFFFF0 && !CORE_HOLD_O &&
    $past(q.state) == cxe_pkg::ST_START;
  endproperty
  a_start: assert property (p_start) else $error("bad start fetch");

  property p_div;
    CLK_DIV2_O ##1 1'b1 |-> !CLK_DIV2_O;
  endproperty
  a_div: assert property (p_div) else $error("clock not halved");

  property p_table;
    VEC_FETCH_O |-> VEC_TABLE_ADDR_O == 10'(VEC_TYPE_O * 4);
  endproperty
  a_table: assert property (p_table) else $error("bad table address");
endmodule

/* File: hw/cxe_map.svh */
// Offsets, field positions, reset values and timing counts of the entry unit.
`ifndef CXE_MAP_SVH
`define CXE_MAP_SVH
`define CXE_CLK_NS 40
`define CXE_STARTUP_NS 240
`define CXE_STARTUP_CYC ((`CXE_STARTUP_NS + `CXE_CLK_NS - 1) / `CXE_CLK_NS)
`define CXE_OFF_RELOC 8'h00
`define CXE_OFF_USEL 8'h04
`define CXE_OFF_PRIO 8'h08
`define CXE_OFF_STATE 8'h0C
`define CXE_OFF_LASTVEC 8'h10
`define CXE_RST_SW 16'hF002
`define CXE_RST_CS 16'hFFFF
`define CXE_RST_IP 16'h0000
`define CXE_RST_SEG 16'h0000
`define CXE_RST_RELOC 16'h20FF
`define CXE_RST_USEL 16'hFFFB
`define CXE_RST_PRIO 21'h000000
`define CXE_SW_STEP 8
`define CXE_SW_IF 9
`define CXE_RELOC_TRAP_BIT 14
`define CXE_COP_TOP 5'h1B
`define CXE_VEC_STEP 8'h01
`define CXE_VEC_NMI 8'h02
`define CXE_VEC_BRK 8'h03
`define CXE_VEC_OVF 8'h04
`define CXE_VEC_RANGE 8'h05
`define CXE_VEC_UNDEF 8'h06
`define CXE_VEC_COP 8'h07
`define CXE_VEC_TMR0 8'h08
`define CXE_VEC_TMR1 8'h12
`define CXE_VEC_TMR2 8'h13
`define CXE_VEC_DMA0 8'h0A
`define CXE_VEC_PIN0 8'h0C
`define CXE_NUM_SRC 7
`define CXE_RESP_OKAY 2'h0
`define CXE_RESP_DECERR 2'h3
`endif

/* File: hw/cxe_pkg.sv */
// Types shared by the exception entry unit.
package cxe_pkg;
  typedef enum logic [2:0] {
    ST_HOLD, ST_START, ST_RUN, ST_PUSH_SW, ST_PUSH_CS, ST_PUSH_IP, ST_VEC
  } cxe_state_e;

  typedef struct packed {
    cxe_state_e state;
    logic [3:0] cnt;
    logic div;
    logic poc_s1;
    logic poc_s2;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic nmi_s1;
    logic nmi_s2;
    logic nmi_s3;
    logic nmi_pend;
    logic [15:0] sw;
    logic [15:0] ret_cs;
    logic [15:0] ret_ip;
    logic [7:0] vec;
    logic ack_cyc;
    logic [15:0] reloc;
    logic [15:0] usel;
    logic [20:0] prio;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic stk_wr;
    logic [15:0] stk_data;
    logic vec_go;
    logic fetch_go;
    logic seg_load;
  } cxe_state_s;
endpackage

/* File: hw/cxe_req_if.sv */
// Maskable request lines and grant between the entry unit and its arbiter.
interface cxe_req_if;
  logic [6:0] req;
  logic [2:0] tmr;
  logic [20:0] prio_cfg;
  logic grant;
  logic [7:0] gvec;
  logic gpin;
  modport arb (input req, tmr, prio_cfg, output grant, gvec, gpin);
  modport src (output req, tmr, prio_cfg, input grant, gvec, gpin);
endinterface

/* File: hw/cxe_prio.sv */
// Priority resolver for the maskable request sources.
`include "cxe_map.svh"
module cxe_prio (
  cxe_req_if.arb rq // Requests in, winning source out.
);
  // Source 0 is the timer group, 1 and 2 the DMA channels, 3 to 6 the pins.
  function automatic logic all_unique(input logic [20:0] p);
    logic u;
    u = 1'b1;
    for (int i = 0; i < `CXE_NUM_SRC; i++) begin
      for (int j = i + 1; j < `CXE_NUM_SRC; j++) begin
        if (p[i*3 +: 3] == p[j*3 +: 3]) begin
          u = 1'b0;
        end
      end
    end
    return u;
  endfunction

  function automatic logic [7:0] src_vec(input int s, input logic [2:0] t);
    logic [7:0] v;
    v = `CXE_VEC_PIN0 + 8'(s - 3);
    if (s == 0) begin
      v = t[0] ? `CXE_VEC_TMR0 : (t[1] ? `CXE_VEC_TMR1 : `CXE_VEC_TMR2);
    end else if (s < 3) begin
      v = `CXE_VEC_DMA0 + 8'(s - 1);
    end
    return v;
  endfunction

  logic use_prog;
  logic found;
  logic [2:0] best;
  logic [2:0] key;
  logic [7:0] vec;
  logic pin;

  assign use_prog = all_unique(rq.prio_cfg);

  always_comb begin
    found = 1'b0;
    best = 3'h0;
    key = 3'h0;
    vec = 8'h00;
    pin = 1'b0;
    for (int s = 0; s < `CXE_NUM_SRC; s++) begin
      // Programmed levels win only when every source has its own level.
      key = use_prog ? rq.prio_cfg[s*3 +: 3] : 3'(s);
      if (rq.req[s] && (!found || key < best)) begin
        found = 1'b1;
        best = key;
        vec = src_vec(s, rq.tmr);
        pin = (s >= 3);
      end
    end
  end

  assign rq.grant = found;
  assign rq.gvec = vec;
  assign rq.gpin = pin;
endmodule

/* File: sim/cxe_src_model.sv */
// Model of the maskable request sources facing the entry unit.
module cxe_src_model (
  input wire logic clk_i, // System clock.
  input wire logic [8:0] post_i, // Raise {timers, dma, pins}.
  input wire logic vec_fetch_i, // Handler pointer fetch.
  input wire logic [7:0] vec_type_i, // Type being entered.
  output logic [3:0] pins_o, // Pin requests.
  output logic [1:0] dma_o, // DMA requests.
  output logic [2:0] tmr_o // Timer requests.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Each source has its own vector, timers included.
  localparam logic [7:0] VT [9] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h0A,
    8'h0B, 8'h08, 8'h12, 8'h13};
  logic [8:0] pend_r = 9'h000;
  // A request stays up until its own entry is seen, as a level source would.
  always @(posedge clk_i) begin
    for (int i = 0; i < 9; i++) begin
      if (post_i[i])
        pend_r[i] <= 1'b1;
      else if (vec_fetch_i && vec_type_i == VT[i])
        pend_r[i] <= 1'b0;
    end
  end
  assign {tmr_o, dma_o, pins_o} = pend_r;
endmodule

/* File: sim/cxe_top_test.sv */
// Self-checking testbench of the exception and reset entry unit.
module cxe_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS_I = 1'b0, RST_B_I = 1'b0, POWER_ON_CLEAR_IN_N_I = 1'b1;
  logic [3:0] MASKABLE_REQUEST_PINS_I;
  logic [1:0] DMA_REQ_I;
  logic [2:0] TIMER_REQ_I;
  logic NMI_PIN_I = 1'b0, BOUNDARY_I = 1'b0, UNDEF_OP_I, BREAKPOINT_I;
  logic OVF_CHECK_I, OVERFLOW_FLAG_I, RANGE_CHECK_I, SEG_PREFIX_I, NO_STEP_I;
  logic RETURN_FROM_HANDLER_I = 1'b0, STATUS_WR_I = 1'b0;
  logic [7:0] OPCODE_I = 8'h90, S_AXI_AWADDR_I = 8'h00, S_AXI_ARADDR_I = 8'h00;
  logic [15:0] RANGE_INDEX_I = 16'h0000, RANGE_LOW_I = 16'h0000;
  logic [15:0] RANGE_HIGH_I = 16'h0003, POPPED_STATUS_I = 16'h0000;
  logic [15:0] STATUS_DATA_I = 16'h0000, INSTR_CS_I = 16'h1234;
  logic [15:0] INSTR_IP_I = 16'h0100, NEXT_IP_I = 16'h0103;
  logic [31:0] S_AXI_WDATA_I = 32'h00000000;
  logic [3:0] S_AXI_WSTRB_I = 4'hF;
  logic S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0, S_AXI_BREADY_I = 1'b0;
  logic S_AXI_ARVALID_I = 1'b0, S_AXI_RREADY_I = 1'b0;
  logic CORE_HOLD_O, CLK_DIV2_O, FETCH_GO_O, SEG_LOAD_O, STACK_WR_O;
  logic VEC_FETCH_O, ACK_CYCLE_O, S_AXI_AWREADY_O, S_AXI_WREADY_O;
  logic S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
  logic [19:0] FETCH_ADDR_O;
  logic [15:0] SEG_CS_O, SEG_OTHER_O, STACK_DATA_O, STATUS_WORD_O;
  logic [9:0] VEC_TABLE_ADDR_O;
  logic [7:0] VEC_TYPE_O;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
  logic [31:0] S_AXI_RDATA_O;
  logic [6:0] cls = 7'h00;
  logic [8:0] post = 9'h000;
  int miscompares = 0;
  int checks = 0;
  assign {UNDEF_OP_I, BREAKPOINT_I, OVF_CHECK_I, OVERFLOW_FLAG_I} = cls[6:3];
  assign {RANGE_CHECK_I, SEG_PREFIX_I, NO_STEP_I} = cls[2:0];
  cxe_top cxe_top_i (.*);
  cxe_src_model cxe_src_model_i (.clk_i(CLK_SYS_I), .post_i(post),
    .vec_fetch_i(VEC_FETCH_O), .vec_type_i(VEC_TYPE_O),
    .pins_o(MASKABLE_REQUEST_PINS_I), .dma_o(DMA_REQ_I), .tmr_o(TIMER_REQ_I));
  always #20 CLK_SYS_I = ~CLK_SYS_I;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw, w, b;
    b = 1'b0;
    @(posedge CLK_SYS_I);
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= d;
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_WVALID_I <= 1'b1;
    S_AXI_BREADY_I <= 1'b1;
    while (!b) begin
      @(negedge CLK_SYS_I);
      aw = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
      w = S_AXI_WVALID_I && S_AXI_WREADY_O;
      b = S_AXI_BVALID_O && S_AXI_BREADY_I;
      if (b) chk(S_AXI_BRESP_O, er);
      @(posedge CLK_SYS_I);
      if (aw) S_AXI_AWVALID_I <= 1'b0;
      if (w) S_AXI_WVALID_I <= 1'b0;
    end
    S_AXI_BREADY_I <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic ar, r;
    r = 1'b0;
    @(posedge CLK_SYS_I);
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1'b1;
    S_AXI_RREADY_I <= 1'b1;
    while (!r) begin
      @(negedge CLK_SYS_I);
      ar = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
      r = S_AXI_RVALID_O && S_AXI_RREADY_I;
      if (r) chk(S_AXI_RDATA_O, ed);
      if (r) chk(S_AXI_RRESP_O, er);
      @(posedge CLK_SYS_I);
      if (ar) S_AXI_ARVALID_I <= 1'b0;
    end
    S_AXI_RREADY_I <= 1'b0;
  endtask
  task automatic kls(input logic [6:0] c, input logic [15:0] x,
                     input logic [7:0] op);
    @(posedge CLK_SYS_I);
    cls <= c;
    RANGE_INDEX_I <= x;
    OPCODE_I <= op;
  endtask
  // Software write (r low) or handler return (r high) of the status word.
  task automatic sts(input logic r, input logic [15:0] v);
    @(posedge CLK_SYS_I);
    STATUS_WR_I <= !r;
    RETURN_FROM_HANDLER_I <= r;
    STATUS_DATA_I <= v;
    POPPED_STATUS_I <= v;
    @(posedge CLK_SYS_I);
    STATUS_WR_I <= 1'b0;
    RETURN_FROM_HANDLER_I <= 1'b0;
  endtask
  task automatic fire(input logic t, input logic [7:0] v,
                      input logic [15:0] sw, input logic [15:0] ip,
                      input logic ack);
    @(posedge CLK_SYS_I);
    BOUNDARY_I <= 1'b1;
    @(posedge CLK_SYS_I);
    BOUNDARY_I <= 1'b0;
    #1 chk(CORE_HOLD_O, t);
    if (t) begin
      chk(STACK_WR_O, 1'b1);
      chk(STACK_DATA_O, sw);
      @(posedge CLK_SYS_I);
      #1 chk(STACK_DATA_O, INSTR_CS_I);
      @(posedge CLK_SYS_I);
      #1 chk(STACK_DATA_O, ip);
      @(posedge CLK_SYS_I);
      #1 chk(VEC_FETCH_O, 1'b1);
      chk(VEC_TYPE_O, v);
      chk(VEC_TABLE_ADDR_O, {v, 2'b00});
      chk(ACK_CYCLE_O, ack);
      chk(STATUS_WORD_O[9:8], 2'b00);
    end
  endtask
  task automatic t_start();
    int n;
    logic d;
    n = 0;
    while (FETCH_GO_O !== 1'b1 && n < 40) begin
      chk(CORE_HOLD_O, 1'b1);
      @(posedge CLK_SYS_I);
      #1 n++;
    end
    chk(FETCH_ADDR_O, 20'hFFFF0);
    chk(SEG_LOAD_O, 1'b1);
    chk({SEG_CS_O, SEG_OTHER_O}, 32'hFFFF0000);
    chk(CORE_HOLD_O, 1'b0);
    d = CLK_DIV2_O;
    @(posedge CLK_SYS_I);
    #1 chk(CLK_DIV2_O, !d);
  endtask
  task automatic t_exc();
    kls(7'h60, 0, 8'h90);
    fire(1, 8'h06, 16'hF002, 16'h0103, 0);
    kls(7'h20, 0, 8'h90);
    fire(1, 8'h03, 16'hF002, 16'h0103, 0);
    kls(7'h10, 0, 8'h90);
    fire(0, 0, 0, 0, 0);
    kls(7'h18, 0, 8'h90);
    fire(1, 8'h04, 16'hF002, 16'h0103, 0);
    kls(7'h04, 3, 8'h90);
    fire(0, 0, 0, 0, 0);
    kls(7'h04, 4, 8'h90);
    fire(1, 8'h05, 16'hF002, 16'h0103, 0);
    kls(7'h00, 0, 8'hD8);
    fire(0, 0, 0, 0, 0);
    wr(8'h00, 32'h000060FF, 2'h0);
    kls(7'h02, 0, 8'hDF);
    fire(1, 8'h07, 16'hF002, 16'h00FF, 0);
    kls(7'h00, 0, 8'hDB);
    fire(1, 8'h07, 16'hF002, 16'h0100, 0);
    kls(7'h00, 0, 8'h90);
  endtask
  task automatic t_mask();
    @(posedge CLK_SYS_I);
    post <= 9'h0C1;
    @(posedge CLK_SYS_I);
    post <= 9'h000;
    fire(0, 0, 0, 0, 0);
    sts(0, 16'hF202);
    fire(1, 8'h08, 16'hF202, 16'h0103, 0);
    fire(0, 0, 0, 0, 0);
    sts(0, 16'hF202);
    fire(1, 8'h12, 16'hF202, 16'h0103, 0);
    sts(1, 16'hF202);
    fire(1, 8'h0C, 16'hF202, 16'h0103, 1);
  endtask
  task automatic t_nmi_step();
    @(posedge CLK_SYS_I);
    NMI_PIN_I <= 1'b1;
    repeat (4) @(posedge CLK_SYS_I);
    fire(1, 8'h02, 16'hF002, 16'h0103, 0);
    @(posedge CLK_SYS_I);
    NMI_PIN_I <= 1'b0;
    sts(0, 16'hF102);
    kls(7'h01, 0, 8'h90);
    fire(0, 0, 0, 0, 0);
    kls(7'h00, 0, 8'h90);
    fire(1, 8'h01, 16'hF102, 16'h0103, 0);
  endtask
  // Unique programmed levels put DMA channel 1 ahead of channel 0.
  task automatic t_prio();
    wr(8'h08, 32'h0000A72E, 2'h0);
    rd(8'h08, 32'h0000A72E, 2'h0);
    @(posedge CLK_SYS_I);
    post <= 9'h030;
    @(posedge CLK_SYS_I);
    post <= 9'h000;
    sts(0, 16'hF202);
    fire(1, 8'h0B, 16'hF202, 16'h0103, 0);
    sts(0, 16'hF202);
    fire(1, 8'h0A, 16'hF202, 16'h0103, 0);
    rd(8'h10, 32'h0000000A, 2'h0);
  endtask
  // The reset pin in mid-run reloads the registers but keeps priorities.
  task automatic t_poc();
    sts(0, 16'hF302);
    @(posedge CLK_SYS_I);
    POWER_ON_CLEAR_IN_N_I <= 1'b0;
    repeat (4) @(posedge CLK_SYS_I);
    #1 chk(CORE_HOLD_O, 1'b1);
    chk(STATUS_WORD_O, 16'hF002);
    @(posedge CLK_SYS_I);
    POWER_ON_CLEAR_IN_N_I <= 1'b1;
    t_start();
    rd(8'h00, 32'h000020FF, 2'h0);
    rd(8'h08, 32'h0000A72E, 2'h0);
  endtask
  initial begin
    repeat (10) @(posedge CLK_SYS_I);
    RST_B_I <= 1'b1;
    #1 chk(STATUS_WORD_O, 16'hF002);
    t_start();
    rd(8'h00, 32'h000020FF, 2'h0);
    rd(8'h04, 32'h0000FFFB, 2'h0);
    rd(8'h40, 32'h00000000, 2'h3);
    wr(8'h40, 32'h00000001, 2'h3);
    t_exc();
    t_mask();
    t_nmi_step();
    t_prio();
    t_poc();
    finish_test();
  end
  // The whole run needs well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge CLK_SYS_I);
    miscompares++;
    finish_test();
  end
endmodule
